// ---- design/pll_feedback_divider_ctrl.sv ----
// pll_feedback_divider_ctrl: serial word latching, pulse-swallow feedback
// divider, reference counter, phase comparator and power control.
// assumes: rfIn and oscIn are slow enough to be sampled by ref_clk;
// serialClk is the link clock and may stop between words.
`timescale 1ns/1ns
`default_nettype none
`include "pll_fb_regs.svh"

// Overview of operation
// R1 - shift msb first, latch on strobe rise
// R2 - select bit 1 reference, 0 feedback
// R3 - select low: 17 data bits to feedback
// R4 - main 16:7, swallow 6:2, control 1:0
// R5 - swallow count is plain binary 0-31
// R6 - host keeps main count 3 to 1023
// R7 - host keeps main not below swallow
// R8 - divide by 33 swallow times, then 32
// R9 - ratio equals 32 times main plus swallow
// R10 - clear bit resets both counters
// R11 - counters restart aligned after clear
// R12 - sync power-down waits for pump pulse end
// R13 - both bits or chip disable: immediate down
// R14 - serial path works in every power-down
// R15 - counters held, restart from zero state
// R16 - host presents bits for rising shift edge
// R17 - power-down tristates pump and comparator
// R18 - enabled, bits clear: normal free running
module pll_feedback_divider_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // serial link
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadStrobe,
  // pins
  input wire logic chipEnable,
  input wire logic rfIn,
  input wire logic oscIn,
  // pump output, three-state
  output logic pumpOut,
  output logic pumpOeN,
  // status
  output logic powerDown,
  output logic fbPulse,
  output logic refPulse,
  output pll_fb_pkg::main_count_t mainCount,
  output pll_fb_pkg::swallow_count_t swallowCount,
  output pll_fb_pkg::control_pair_t controlPair
);
  import pll_fb_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    data_word_t fbWord;
    data_word_t refWord;
    power_mode_e mode;
    logic ldPrev;
    logic rfPrev;
    logic oscPrev;
    logic [5:0] preCnt;
    swallow_count_t swallowLeft;
    main_count_t mainLeft;
    logic [9:0] refCnt;
    logic pumpUp;
    logic pumpDown;
    logic fbPulse;
    logic refPulse;
    logic [15:0] ratioCnt;
    logic wordDirty;
    logic reloadLoad;
  } ctrl_s;

  ctrl_s st;
  ctrl_s next_st;
  shift_word_t shiftWord;
  logic [3:0] pinSync;
  logic ldSync;
  logic ceSync;
  logic rfSync;
  logic oscSync;
  logic ldRise;
  logic ldFeedback;
  logic rfEv;
  logic oscEv;
  logic asyncDown;
  logic counting;
  logic pumpBusy;
  logic pumpIdle;
  logic preLast;
  logic reload;
  logic up;
  logic down;

  // field decoders
  function automatic main_count_t mainOf(input data_word_t w);
    mainOf = w[`MAIN_MSB:`MAIN_LSB]; // [R4]
  endfunction

  function automatic swallow_count_t swallowOf(input data_word_t w);
    swallowOf = w[`SWAL_MSB:`SWAL_LSB]; // [R4] [R5]
  endfunction

  function automatic control_pair_t ctlOf(input data_word_t w);
    ctlOf = w[`CTL_MSB:`CTL_LSB]; // [R4]
  endfunction

  function automatic logic isCounting(input power_mode_e m);
    isCounting = (m == PM_RUN) || (m == PM_SYNC_WAIT);
  endfunction

  // ------------------------------------------------------------------
  // link side and pin synchronisers
  // ------------------------------------------------------------------
  serial_shift shifter (
    .serialClk(serialClk),
    .serialData(serialData),
    .shiftWord(shiftWord)
  );

  bit_sync #(.WIDTH(4)) pins (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .asyncIn({loadStrobe, chipEnable, rfIn, oscIn}),
    .syncOut(pinSync)
  );

  assign {ldSync, ceSync, rfSync, oscSync} = pinSync;

  // events and mode qualifiers
  assign ldRise = ldSync & ~st.ldPrev;
  assign ldFeedback = ldRise & (shiftWord[`ADDR_BIT] == `ADDR_FEEDBACK);
  assign rfEv = rfSync & ~st.rfPrev;
  assign oscEv = oscSync & ~st.oscPrev;
  assign asyncDown = ~ceSync | (ctlOf(st.fbWord) == `CTL_ASYNC_PD); // [R13]
  // clear bit stops the counters at once, not one cycle after the mode moves
  assign counting = isCounting(st.mode) & ~asyncDown & (ctlOf(st.fbWord) != `CTL_CLEAR); // [R10]
  assign pumpBusy = st.pumpUp | st.pumpDown;
  // a divider pulse this cycle starts a pump event, so it is not idle yet
  assign pumpIdle = ~pumpBusy & ~st.refPulse & ~st.fbPulse; // [R12]
  assign preLast = (st.preCnt == ((st.swallowLeft != '0) ? `PRESCALE_MOD : `PRESCALE_MOD - 6'h01)); // [R8]
  assign reload = counting & rfEv & preLast & (st.mainLeft <= 10'h001);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ldPrev = ldSync;
    next_st.rfPrev = rfSync;
    next_st.oscPrev = oscSync;
    next_st.fbPulse = 1'b0;
    next_st.refPulse = 1'b0;
    up = 1'b0;
    down = 1'b0;

    // latch the data field into the addressed word
    if (ldRise)
    begin
      if (ldFeedback)
        next_st.fbWord = shiftWord[`SHIFT_W-1:1]; // [R1] [R2] [R3] [R14]
      else
        next_st.refWord = shiftWord[`SHIFT_W-1:1]; // [R2]
    end

    // power mode
    if (asyncDown)
      next_st.mode = PM_DOWN; // [R13]
    else
    begin
      case (ctlOf(st.fbWord))
        `CTL_NORMAL: next_st.mode = PM_RUN; // [R18]
        `CTL_CLEAR: next_st.mode = PM_CLEAR; // [R10]
        `CTL_SYNC_PD: next_st.mode = (st.mode == PM_DOWN || pumpIdle) ? PM_DOWN : PM_SYNC_WAIT; // [R12]
        default: next_st.mode = PM_DOWN;
      endcase
    end

    if (counting)
    begin
      // pulse-swallow feedback divider
      if (rfEv)
      begin
        next_st.preCnt = st.preCnt + 6'h01;
        if (preLast)
        begin
          next_st.preCnt = '0;
          if (st.swallowLeft != '0)
            next_st.swallowLeft = st.swallowLeft - 5'h01; // [R8]
          next_st.mainLeft = st.mainLeft - 10'h001;
          if (reload)
          begin
            next_st.fbPulse = 1'b1; // [R9]
            next_st.swallowLeft = swallowOf(st.fbWord);
            next_st.mainLeft = mainOf(st.fbWord);
          end
        end
      end
      // reference counter
      if (oscEv)
      begin
        if (st.refCnt >= st.refWord[`REF_CNT_MSB:`REF_CNT_LSB] - 10'h001)
        begin
          next_st.refCnt = '0;
          next_st.refPulse = 1'b1;
        end
        else
          next_st.refCnt = st.refCnt + 10'h001;
      end
      // phase comparator: both flags set cancel each other
      up = st.pumpUp | st.refPulse;
      down = st.pumpDown | st.fbPulse;
      next_st.pumpUp = up & ~down;
      next_st.pumpDown = down & ~up;
      next_st.ratioCnt = st.fbPulse ? {15'h0000, rfEv} : st.ratioCnt + {15'h0000, rfEv};
    end
    else
    begin
      // hold both counters at load point, comparator idle
      next_st.preCnt = '0; // [R10] [R11] [R15]
      next_st.refCnt = '0; // [R10] [R15]
      next_st.swallowLeft = swallowOf(st.fbWord);
      next_st.mainLeft = mainOf(st.fbWord);
      next_st.pumpUp = 1'b0; // [R17]
      next_st.pumpDown = 1'b0;
      next_st.ratioCnt = '0;
    end

    // period bookkeeping for the ratio check, a load wins;
    // a load in the reload cycle still marks the following period
    if (!counting)
      next_st.wordDirty = 1'b0;
    else if (st.fbPulse)
      next_st.wordDirty = st.reloadLoad;
    if (ldFeedback)
      next_st.wordDirty = 1'b1;
    next_st.reloadLoad = reload & ldFeedback;
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.fbWord <= `FB_WORD_RESET;
      st.refWord <= `REF_WORD_RESET;
      st.mode <= PM_DOWN;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign pumpOut = st.pumpUp;
  assign pumpOeN = ~(counting & pumpBusy); // [R13] [R17]
  assign powerDown = (st.mode == PM_DOWN);
  assign fbPulse = st.fbPulse;
  assign refPulse = st.refPulse;
  assign mainCount = mainOf(st.fbWord);
  assign swallowCount = swallowOf(st.fbWord);
  assign controlPair = ctlOf(st.fbWord);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_FB_LOAD: assert property (ldFeedback |=> st.fbWord == $past(shiftWord[`SHIFT_W-1:1])) // [R3] [R14]
    else $error("feedback word not latched");
  AST_REF_LOAD: assert property (ldRise && shiftWord[`ADDR_BIT] |=> $stable(st.fbWord)) // [R2]
    else $error("reference load disturbed feedback word");
  AST_CLEAR_HOLD: assert property (st.mode == PM_CLEAR |-> st.preCnt == '0 && st.refCnt == '0) // [R10]
    else $error("counters run during clear");
  AST_ASYNC_DOWN: assert property (asyncDown |-> pumpOeN ##1 st.mode == PM_DOWN) // [R13]
    else $error("asynchronous power-down late");
  AST_SYNC_WAIT: assert property (st.mode == PM_SYNC_WAIT && pumpIdle && !asyncDown
    && controlPair == `CTL_SYNC_PD |=> st.mode == PM_DOWN) // [R12]
    else $error("synchronous power-down not taken");
  AST_SYNC_HOLD: assert property (st.mode == PM_RUN && pumpBusy && !asyncDown
    && controlPair == `CTL_SYNC_PD |=> st.mode == PM_SYNC_WAIT) // [R12]
    else $error("synchronous power-down cut a pump pulse");
  AST_DOWN_TRI: assert property (st.mode == PM_DOWN |-> pumpOeN && !st.pumpUp && !st.pumpDown) // [R17]
    else $error("pump driven in power-down");
  AST_POWER_UP_ZERO: assert property (st.mode == PM_DOWN ##1 st.mode == PM_RUN
    |-> st.preCnt == '0 && st.refCnt == '0 && st.mainLeft == mainCount) // [R15] [R11]
    else $error("counters not at zero on power-up");
  AST_PRESCALE_33: assert property (counting && rfEv && st.swallowLeft != '0
    && st.preCnt == `PRESCALE_MOD |=> st.preCnt == '0) // [R8]
    else $error("swallow period not 33");
  AST_PRESCALE_32: assert property (st.swallowLeft == '0 |-> st.preCnt < `PRESCALE_MOD) // [R8]
    else $error("normal period not 32");
  AST_RATIO: assert property (st.fbPulse && !st.wordDirty |-> st.ratioCnt == {1'b0, mainCount, swallowCount}) // [R9]
    else $error("feedback ratio wrong");
  AST_NORMAL: assert property (ceSync && controlPair == `CTL_NORMAL |=> st.mode == PM_RUN) // [R18]
    else $error("normal operation not entered");

  COV_FB_PULSE: cover property (st.mode == PM_RUN && st.fbPulse);
  COV_SYNC_DOWN: cover property (st.mode == PM_SYNC_WAIT ##1 st.mode == PM_DOWN);
  COV_CE_DOWN: cover property (!ceSync && st.mode == PM_RUN);
  COV_CLEAR: cover property (st.mode == PM_CLEAR ##1 st.mode == PM_RUN);

endmodule

`default_nettype wire

// ---- design/pll_fb_regs.svh ----
// pll_fb_regs.svh: field positions, codes and reset values of the
// feedback-divider control block; definitions only.
// assumes: included by bare name from the package and the design files.
`ifndef PLL_FB_REGS_SVH
`define PLL_FB_REGS_SVH

// --------------------------------------------------------------------
// serial word layout
// --------------------------------------------------------------------
`define SHIFT_W 18
`define DATA_W 17
`define ADDR_BIT 0
`define ADDR_FEEDBACK 1'h0
`define MAIN_MSB 16
`define MAIN_LSB 7
`define SWAL_MSB 6
`define SWAL_LSB 2
`define CTL_MSB 1
`define CTL_LSB 0
`define REF_CNT_MSB 9
`define REF_CNT_LSB 0

// --------------------------------------------------------------------
// control pair codes, prescaler and reset values
// --------------------------------------------------------------------
`define CTL_NORMAL 2'h0
`define CTL_SYNC_PD 2'h1
`define CTL_CLEAR 2'h2
`define CTL_ASYNC_PD 2'h3
`define PRESCALE_MOD 6'h20
`define FB_WORD_RESET 17'h00003
`define REF_WORD_RESET 17'h00002

`endif

// ---- design/pll_fb_pkg.sv ----
// pll_fb_pkg: types shared by the feedback-divider control block.
// assumes: pll_fb_regs.svh is on the include path.
`include "pll_fb_regs.svh"

package pll_fb_pkg;

  typedef logic [`SHIFT_W-1:0] shift_word_t;
  typedef logic [`DATA_W-1:0] data_word_t;
  typedef logic [`MAIN_MSB-`MAIN_LSB:0] main_count_t;
  typedef logic [`SWAL_MSB-`SWAL_LSB:0] swallow_count_t;
  typedef logic [`CTL_MSB-`CTL_LSB:0] control_pair_t;

  // power modes, gray along run -> sync wait -> down
  typedef enum logic [1:0]
  {
    PM_RUN = 2'h0,
    PM_SYNC_WAIT = 2'h1,
    PM_DOWN = 2'h3,
    PM_CLEAR = 2'h2
  } power_mode_e;

endpackage

// ---- design/bit_sync.sv ----
// bit_sync: two flip-flop level synchroniser for a group of pins.
// assumes: every bit is an independent level; reset is synchronous.
`timescale 1ns/1ns
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // first stage feeds only the second stage
  always_comb
  begin
    next_st.stage1 = asyncIn;
    next_st.stage2 = st.stage1;
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign syncOut = st.stage2;

endmodule

`default_nettype wire

// ---- design/serial_shift.sv ----
// serial_shift: 18-bit serial input register on the link's shift clock.
// assumes: the host stops the shift clock while the load strobe moves.
`timescale 1ns/1ns
`default_nettype none
`include "pll_fb_regs.svh"

module serial_shift (
  // link
  input wire logic serialClk,
  input wire logic serialData,
  // parallel word
  output pll_fb_pkg::shift_word_t shiftWord
);
  import pll_fb_pkg::*;

  typedef struct packed {
    shift_word_t word;
  } shift_s;

  shift_s st;
  shift_s next_st;

  // msb enters first, so it ends at the top
  always_comb
  begin
    next_st.word = {st.word[`SHIFT_W-2:0], serialData}; // [R1]
  end

  // runs in every power mode, never gated
  always_ff @(posedge serialClk)
  begin
    st <= next_st; // [R14]
  end

  assign shiftWord = st.word;

endmodule

`default_nettype wire

// ---- sim/serial_host.sv ----
// serial_host: host side of the three-wire word loading link.
// assumes: ref_clk paces the strobe; the link clock runs only inside words.
`timescale 1ns/1ns
`default_nettype none
`include "pll_fb_regs.svh"

module serial_host (
  // pacing clock
  input wire logic ref_clk,
  // link
  output logic serialClk,
  output logic serialData,
  output logic loadStrobe
);
  import pll_fb_pkg::*;

  // link idle at time zero
  initial
  begin
    serialClk = 1'b0;
    serialData = 1'b0;
    loadStrobe = 1'b0;
  end

  // 18 bits msb first at 12 ns, then a strobe pulse of 4 cycles
  task automatic send(input shift_word_t word);
    @(negedge ref_clk);
    #5;
    for (int i = `SHIFT_W - 1; i >= 0; i--)
    begin
      serialData = word[i];
      #6 serialClk = 1'b1;
      #6 serialClk = 1'b0;
    end
    serialData = ~word[0]; // line left driven to the inverse of the last bit
    @(negedge ref_clk);
    loadStrobe = 1'b1;
    repeat (4) @(negedge ref_clk);
    loadStrobe = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// tb: self-checking bench of the feedback-divider control block.
// assumes: serial_host drives the link; rf and osc pins toggle every 2 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pll_fb_regs.svh"

module tb;
  import pll_fb_pkg::*;
  logic ref_clk, resetn, chipEnable;
  logic [1:0] phase;
  wire logic serialClk, serialData, loadStrobe, rfIn, oscIn;
  logic pumpOut, pumpOeN, powerDown, fbPulse, refPulse;
  main_count_t mainCount;
  swallow_count_t swallowCount;
  control_pair_t controlPair;
  int failures, num_checks, cycles, n;

  // ----------------------------------------
  // clock, pins and timeout
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // one rf and osc rising edge every 4 cycles
  always @(negedge ref_clk) phase <= phase + 2'h1;
  assign rfIn = phase[1];
  assign oscIn = phase[1];
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      end_sim();
    end
  end

  serial_host host (.ref_clk(ref_clk), .serialClk(serialClk), .serialData(serialData), .loadStrobe(loadStrobe));
  pll_feedback_divider_ctrl uut (.ref_clk(ref_clk), .resetn(resetn), .serialClk(serialClk),
    .serialData(serialData), .loadStrobe(loadStrobe), .chipEnable(chipEnable), .rfIn(rfIn),
    .oscIn(oscIn), .pumpOut(pumpOut), .pumpOeN(pumpOeN), .powerDown(powerDown), .fbPulse(fbPulse),
    .refPulse(refPulse), .mainCount(mainCount), .swallowCount(swallowCount), .controlPair(controlPair));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask
  // cycles until the chosen pulse, or limit
  task automatic wait_pulse(input logic useRef, input int limit, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge ref_clk);
      cnt++;
    end while (((useRef ? refPulse : fbPulse) !== 1'b1) && cnt < limit);
  endtask
  function automatic shift_word_t fb_word(main_count_t m, swallow_count_t s, control_pair_t c);
    return {m, s, c, `ADDR_FEEDBACK};
  endfunction
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    check("powerDown", 32'(powerDown), 32'h1);
    check("pumpOeN", 32'(pumpOeN), 32'h1);
    check("controlPair", 32'(controlPair), 32'h3);
  endtask
  // largest swallow, main equal to it, ratio 1023
  task automatic test_ratio();
    host.send(fb_word(10'h01F, 5'h1F, `CTL_NORMAL));
    check("mainCount", 32'(mainCount), 32'h1F);
    check("swallowCount", 32'(swallowCount), 32'h1F);
    check("controlPair", 32'(controlPair), 32'h0);
    check("powerDown", 32'(powerDown), 32'h0);
    wait_pulse(1'b0, 6000, n);
    wait_pulse(1'b0, 6000, n);
    check("fb period", n, 32'(4 * (32 * 31 + 31)));
  endtask
  // select bit 1 goes to the reference word only
  task automatic test_ref();
    host.send({7'h00, 10'h005, 1'b1});
    check("mainCount", 32'(mainCount), 32'h1F);
    wait_pulse(1'b1, 100, n);
    wait_pulse(1'b1, 100, n);
    check("ref period", n, 32'h14);
    // a lone reference pulse drives the pump up next cycle
    if (fbPulse === 1'b0)
    begin
      @(negedge ref_clk);
      check("pumpOut", 32'(pumpOut), 32'h1);
      check("pumpOeN", 32'(pumpOeN), 32'h0);
    end
  endtask
  task automatic test_clear();
    host.send(fb_word(10'h01F, 5'h1F, `CTL_CLEAR));
    check("pumpOeN", 32'(pumpOeN), 32'h1);
    wait_pulse(1'b0, 5000, n);
    check("fb held", n, 32'd5000);
    wait_pulse(1'b1, 100, n);
    check("ref held", n, 32'd100);
    host.send(fb_word(10'h01F, 5'h1F, `CTL_NORMAL));
    wait_pulse(1'b0, 6000, n);
    check("first fb", 32'(n >= 4080 && n <= 4100), 32'h1);
  endtask
  task automatic test_sync_pd();
    host.send(fb_word(10'h01F, 5'h1F, `CTL_SYNC_PD));
    for (int i = 0; i < 9000 && powerDown !== 1'b1; i++) @(negedge ref_clk);
    check("powerDown", 32'(powerDown), 32'h1);
    check("pumpOeN", 32'(pumpOeN), 32'h1);
    host.send(fb_word(10'h003, 5'h02, `CTL_SYNC_PD));
    check("mainCount", 32'(mainCount), 32'h3);
    check("swallowCount", 32'(swallowCount), 32'h2);
    wait_pulse(1'b0, 200, n);
    check("fb held", n, 32'd200);
  endtask
  task automatic test_async_pd();
    host.send(fb_word(10'h01F, 5'h1F, `CTL_NORMAL));
    check("powerDown", 32'(powerDown), 32'h0);
    chipEnable = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("pumpOeN", 32'(pumpOeN), 32'h1);
    check("powerDown", 32'(powerDown), 32'h1);
    chipEnable = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("powerDown", 32'(powerDown), 32'h0);
    host.send(fb_word(10'h01F, 5'h1F, `CTL_ASYNC_PD));
    check("powerDown", 32'(powerDown), 32'h1);
  endtask

  // main sequence, reset held 4 cycles
  initial
  begin
    resetn = 1'b0;
    chipEnable = 1'b1;
    phase = 2'h0;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    test_reset();
    test_ratio();
    test_ref();
    test_clear();
    test_sync_pd();
    test_async_pd();
    end_sim();
  end
endmodule
`default_nettype wire
